// ===== rvs_pkg.sv
// package of constants and types for the sector verify command handler
// What this block does
// [R1] opcodes 40h and 41h both start verify
// [R2] retry bit of the opcode is ignored
// [R3] sectors checked, transfer request never raised
// [R4] uncorrectable sector stops the verify there
// [R5] 8-bit count, zero means 256 sectors
// [R6] mode bit zero: geometric start address
// [R7] mode bit one: 28-bit logical address
// [R8] count returns sectors left unverified
// [R9] address registers return last processed sector
// [R10] error shows only uncorrectable, not-found, aborted
// [R11] ending status: busy, fault, corrected cleared
// [R12] opcode 42h starts the extended verify
// [R13] extended count 16 bits, zero means 65536
// [R14] extended stop returns failing 48-bit address
// [R15] host writes parameters first, waits for busy
package rvs_pkg;

    // ***************************************************
    // register offsets on the plain register port
    // ***************************************************
    localparam logic [3:0] RVS_OFS_COUNT = 4'h0;
    localparam logic [3:0] RVS_OFS_SECNUM = 4'h1;
    localparam logic [3:0] RVS_OFS_CYL_LO = 4'h2;
    localparam logic [3:0] RVS_OFS_CYL_HI = 4'h3;
    localparam logic [3:0] RVS_OFS_DEVHEAD = 4'h4;
    localparam logic [3:0] RVS_OFS_CMD_STAT = 4'h5;
    localparam logic [3:0] RVS_OFS_ERROR = 4'h6;
    localparam logic [3:0] RVS_OFS_DEVCTL = 4'h7;
    localparam logic [3:0] RVS_OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] RVS_OFS_IRQ_MASK = 4'h9;

    // ***************************************************
    // opcodes, field positions and reset values
    // ***************************************************
    localparam logic [6:0] RVS_OP_VERIFY28_HI = 7'h20;
    localparam logic [7:0] RVS_OP_VERIFY48 = 8'h42;
    localparam int RVS_DH_LBA_BIT = 6;
    localparam int RVS_HOB_BIT = 7;
    localparam int RVS_ERR_UNC_BIT = 6;
    localparam int RVS_ERR_IDN_BIT = 4;
    localparam int RVS_ERR_ABT_BIT = 2;
    localparam logic [7:0] RVS_ERR_LEGAL_MASK = 8'h54;
    localparam logic [7:0] RVS_DEVHEAD_RST = 8'ha0;
    localparam logic [7:0] RVS_TF_RST = 8'h00;
    localparam logic [16:0] RVS_COUNT28_ZERO = 17'h00100;
    localparam logic [16:0] RVS_COUNT48_ZERO = 17'h10000;
    localparam int RVS_IRQ_W = 2;
    localparam int RVS_EV_DONE = 0;
    localparam int RVS_EV_ERROR = 1;

    // ***************************************************
    // disk geometry used for geometric address stepping
    // ***************************************************
    localparam logic [7:0] RVS_SECTORS_PER_TRACK = 8'h3f;
    localparam logic [3:0] RVS_LAST_HEAD = 4'hf;

    // ***************************************************
    // types
    // ***************************************************
    typedef enum logic [1:0] {
        RVS_ST_IDLE = 2'b00,
        RVS_ST_ISSUE = 2'b01,
        RVS_ST_WAIT = 2'b10,
        RVS_ST_DONE = 2'b11
    } rvs_state_t;

    // one sector check request towards the media engine
    typedef struct packed {
        logic lba_mode;
        logic [47:0] addr;
    } rvs_media_req_t;

    // answer of the media engine for one sector
    typedef struct packed {
        logic done;
        logic uncorrectable_flag;
        logic idnf;
    } rvs_media_rsp_t;

endpackage : rvs_pkg

// ===== rvs_addr_step.sv
// next sector address in logical or geometric form
`timescale 1ns/1ps
module rvs_addr_step
    import rvs_pkg::*;
(
    input wire logic lba_mode_in, // logical addressing
    input wire logic ext_in, // 48-bit command
    input wire logic [47:0] addr_in, // current sector
    output logic [47:0] next_out // following sector
);

    logic [7:0] sec;
    logic [3:0] head;
    logic [15:0] cyl;

    assign sec = addr_in[7:0];
    assign cyl = addr_in[23:8];
    assign head = addr_in[27:24];

    // step sector, then head, then cylinder in geometric form
    always_comb begin
        next_out = addr_in;
        if (ext_in) begin
            next_out = addr_in + 48'h1;
        end else if (lba_mode_in) begin
            next_out = {20'h0, addr_in[27:0] + 28'h1};
        end else if (sec < RVS_SECTORS_PER_TRACK) begin
            next_out[7:0] = sec + 8'h1;
        end else if (head != RVS_LAST_HEAD) begin
            next_out[7:0] = 8'h1;
            next_out[27:24] = head + 4'h1;
        end else begin
            next_out[7:0] = 8'h1;
            next_out[27:24] = 4'h0;
            next_out[23:8] = cyl + 16'h1;
        end
    end

endmodule : rvs_addr_step

// ===== rvs_irq_unit.sv
// sticky event flags, mask and level interrupt
`timescale 1ns/1ps
module rvs_irq_unit
    import rvs_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic srst_in, // sync reset
    input wire logic [RVS_IRQ_W-1:0] set_in, // event pulses
    input wire logic clr_wr_in, // write to flag register
    input wire logic mask_wr_in, // write to mask register
    input wire logic [RVS_IRQ_W-1:0] wdata_in, // write data
    output logic [RVS_IRQ_W-1:0] flags_out, // sticky flags
    output logic [RVS_IRQ_W-1:0] mask_out, // enable mask
    output logic irq_out // level interrupt
);

    // write one clears, a new event wins over the clear
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flags_out <= '0;
        end else begin
            flags_out <= (flags_out & ~(clr_wr_in ? wdata_in : '0)) | set_in;
        end
    end

    // mask register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mask_out <= '0;
        end else if (mask_wr_in) begin
            mask_out <= wdata_in;
        end
    end

    // interrupt follows flags gated by mask
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(flags_out & mask_out);
        end
    end

endmodule : rvs_irq_unit

// ===== rvs_verify_cmd.sv
// sector verify command handler with task file and register port
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rvs_verify_cmd
    import rvs_pkg::*;
(
    input wire logic clk_in, // clock, 125 MHz
    input wire logic srst_in, // sync reset
    input wire logic [3:0] addr_in, // register offset
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [7:0] rdata_out, // read data, next cycle
    output logic irq_out, // level interrupt
    output logic busy_out, // command running
    output logic media_req_valid_out, // one-cycle sector request
    output rvs_media_req_t media_req_out, // sector address
    input wire rvs_media_rsp_t media_rsp_in // sector result
);

    // ***************************************************
    // declarations
    // ***************************************************
    rvs_state_t state_q;
    logic [7:0] cnt_q, cnt_prev_q;
    logic [7:0] sn_q, sn_prev_q;
    logic [7:0] cl_q, cl_prev_q;
    logic [7:0] ch_q, ch_prev_q;
    logic [7:0] devhead_q;
    logic hob_q;
    logic [7:0] err_q;
    logic errbit_q;
    logic ext_q;
    logic lba_q;
    logic [47:0] cur_addr_q;
    logic [16:0] remain_q;
    logic [47:0] next_addr;
    logic [RVS_IRQ_W-1:0] irq_set;
    logic [RVS_IRQ_W-1:0] irq_flags;
    logic [RVS_IRQ_W-1:0] irq_mask;
    logic cmd_wr;
    logic tf_wr;
    logic go28;
    logic go48;
    logic sector_fail;
    logic [7:0] status;

    // pick the current or previous byte by the high-order select
    function automatic logic [7:0] rvs_hob_pick(input logic sel,
                                                input logic [7:0] cur,
                                                input logic [7:0] prev);
        return sel ? prev : cur;
    endfunction : rvs_hob_pick

    // ***************************************************
    // command decode
    // ***************************************************
    // task file and command writes are only taken while idle
    assign tf_wr = wr_in && (state_q == RVS_ST_IDLE);
    assign cmd_wr = tf_wr && (addr_in == RVS_OFS_CMD_STAT);
    // [R1] both 28-bit opcodes
    // [R2] low opcode bit ignored
    assign go28 = cmd_wr && (wdata_in[7:1] == RVS_OP_VERIFY28_HI);
    // [R12] extended opcode
    assign go48 = cmd_wr && (wdata_in == RVS_OP_VERIFY48);
    // [R4] failing sector ends the range
    assign sector_fail = media_rsp_in.uncorrectable_flag || media_rsp_in.idnf;

    // ***************************************************
    // address stepping and interrupt flags
    // ***************************************************
    rvs_addr_step u_step (
        .lba_mode_in(lba_q),
        .ext_in(ext_q),
        .addr_in(cur_addr_q),
        .next_out(next_addr)
    );

    // completion and error events
    assign irq_set[RVS_EV_DONE] = (state_q == RVS_ST_DONE);
    assign irq_set[RVS_EV_ERROR] = (state_q == RVS_ST_DONE) && errbit_q;

    rvs_irq_unit u_irq (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .set_in(irq_set),
        .clr_wr_in(wr_in && (addr_in == RVS_OFS_IRQ_STAT)),
        .mask_wr_in(wr_in && (addr_in == RVS_OFS_IRQ_MASK)),
        .wdata_in(wdata_in[RVS_IRQ_W-1:0]),
        .flags_out(irq_flags),
        .mask_out(irq_mask),
        .irq_out(irq_out)
    );

    // ***************************************************
    // command sequencer
    // ***************************************************
    // walk the range one sector at a time
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= RVS_ST_IDLE;
            ext_q <= 1'b0;
            lba_q <= 1'b0;
            cur_addr_q <= 48'h0;
            remain_q <= 17'h0;
        end else begin
            case (state_q)
                RVS_ST_IDLE: begin
                    if (go28) begin
                        ext_q <= 1'b0;
                        lba_q <= devhead_q[RVS_DH_LBA_BIT];
                        // [R6] geometric start address
                        // [R7] logical start address
                        cur_addr_q <= {20'h0, devhead_q[3:0], ch_q, cl_q, sn_q};
                        // [R5] zero count is 256
                        remain_q <= (cnt_q == 8'h0) ? RVS_COUNT28_ZERO : {9'h0, cnt_q};
                        state_q <= RVS_ST_ISSUE;
                    end else if (go48) begin
                        ext_q <= 1'b1;
                        lba_q <= 1'b1;
                        cur_addr_q <= {ch_prev_q, cl_prev_q, sn_prev_q, ch_q, cl_q, sn_q};
                        // [R13] zero count is 65536
                        remain_q <= ({cnt_prev_q, cnt_q} == 16'h0) ? RVS_COUNT48_ZERO
                                  : {1'b0, cnt_prev_q, cnt_q};
                        state_q <= RVS_ST_ISSUE;
                    end else if (cmd_wr) begin
                        state_q <= RVS_ST_DONE;
                    end
                end
                RVS_ST_ISSUE: begin
                    state_q <= RVS_ST_WAIT;
                end
                RVS_ST_WAIT: begin
                    if (media_rsp_in.done) begin
                        if (sector_fail) begin
                            // [R4] stop at the failing sector
                            state_q <= RVS_ST_DONE;
                        end else if (remain_q == 17'h1) begin
                            remain_q <= 17'h0;
                            state_q <= RVS_ST_DONE;
                        end else begin
                            remain_q <= remain_q - 17'h1;
                            cur_addr_q <= next_addr;
                            state_q <= RVS_ST_ISSUE;
                        end
                    end
                end
                RVS_ST_DONE: begin
                    state_q <= RVS_ST_IDLE;
                end
                default: begin
                    state_q <= RVS_ST_IDLE;
                end
            endcase
        end
    end

    // [R3] sector check request only, no host transfer
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            media_req_valid_out <= 1'b0;
            media_req_out <= '0;
        end else begin
            media_req_valid_out <= (state_q == RVS_ST_ISSUE);
            media_req_out.lba_mode <= lba_q;
            media_req_out.addr <= cur_addr_q;
        end
    end

    // ***************************************************
    // error and status
    // ***************************************************
    // [R10] only uncorrectable, not found and aborted bits
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            err_q <= 8'h0;
            errbit_q <= 1'b0;
        end else if (cmd_wr) begin
            err_q <= 8'h0;
            errbit_q <= !(go28 || go48);
            err_q[RVS_ERR_ABT_BIT] <= !(go28 || go48);
        end else if (state_q == RVS_ST_WAIT && media_rsp_in.done && sector_fail) begin
            err_q[RVS_ERR_UNC_BIT] <= media_rsp_in.uncorrectable_flag;
            err_q[RVS_ERR_IDN_BIT] <= media_rsp_in.idnf;
            errbit_q <= 1'b1;
        end
    end

    // busy from command write until the ending state
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            busy_out <= 1'b0;
        end else if (cmd_wr) begin
            busy_out <= 1'b1;
        end else if (state_q == RVS_ST_DONE) begin
            busy_out <= 1'b0;
        end
    end

    // [R11] fault, request, corrected and index read zero
    assign status = {busy_out, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, errbit_q};

    // ***************************************************
    // task file registers
    // ***************************************************
    // count, sector and cylinder writes shift current into previous; ending writes back
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_q <= RVS_TF_RST;
            cnt_prev_q <= RVS_TF_RST;
            sn_q <= RVS_TF_RST;
            sn_prev_q <= RVS_TF_RST;
            cl_q <= RVS_TF_RST;
            cl_prev_q <= RVS_TF_RST;
            ch_q <= RVS_TF_RST;
            ch_prev_q <= RVS_TF_RST;
            devhead_q <= RVS_DEVHEAD_RST;
            hob_q <= 1'b0;
        end else if (state_q == RVS_ST_DONE && busy_out && !err_q[RVS_ERR_ABT_BIT]) begin
            // [R8] sectors left unverified
            cnt_q <= remain_q[7:0];
            // [R9] last processed sector
            sn_q <= cur_addr_q[7:0];
            cl_q <= cur_addr_q[15:8];
            ch_q <= cur_addr_q[23:16];
            if (ext_q) begin
                cnt_prev_q <= remain_q[15:8];
                // [R14] upper bytes of the failing address
                sn_prev_q <= cur_addr_q[31:24];
                cl_prev_q <= cur_addr_q[39:32];
                ch_prev_q <= cur_addr_q[47:40];
            end else begin
                devhead_q[3:0] <= cur_addr_q[27:24];
            end
        end else if (tf_wr) begin
            // [R15] parameters accepted only while not busy
            case (addr_in)
                RVS_OFS_COUNT: begin
                    cnt_prev_q <= cnt_q;
                    cnt_q <= wdata_in;
                end
                RVS_OFS_SECNUM: begin
                    sn_prev_q <= sn_q;
                    sn_q <= wdata_in;
                end
                RVS_OFS_CYL_LO: begin
                    cl_prev_q <= cl_q;
                    cl_q <= wdata_in;
                end
                RVS_OFS_CYL_HI: begin
                    ch_prev_q <= ch_q;
                    ch_q <= wdata_in;
                end
                RVS_OFS_DEVHEAD: begin
                    devhead_q <= wdata_in;
                end
                RVS_OFS_DEVCTL: begin
                    hob_q <= wdata_in[RVS_HOB_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ***************************************************
    // read port
    // ***************************************************
    // read data stand one cycle after the strobe only
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h0;
        end else if (!rd_in) begin
            rdata_out <= 8'h0;
        end else begin
            case (addr_in)
                RVS_OFS_COUNT: rdata_out <= rvs_hob_pick(hob_q, cnt_q, cnt_prev_q);
                RVS_OFS_SECNUM: rdata_out <= rvs_hob_pick(hob_q, sn_q, sn_prev_q);
                RVS_OFS_CYL_LO: rdata_out <= rvs_hob_pick(hob_q, cl_q, cl_prev_q);
                RVS_OFS_CYL_HI: rdata_out <= rvs_hob_pick(hob_q, ch_q, ch_prev_q);
                RVS_OFS_DEVHEAD: rdata_out <= devhead_q;
                RVS_OFS_CMD_STAT: rdata_out <= status;
                RVS_OFS_ERROR: rdata_out <= err_q;
                RVS_OFS_DEVCTL: rdata_out <= {hob_q, 7'h0};
                RVS_OFS_IRQ_STAT: rdata_out <= {6'h0, irq_flags};
                RVS_OFS_IRQ_MASK: rdata_out <= {6'h0, irq_mask};
                default: rdata_out <= 8'h0;
            endcase
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    // [R1] opcode 41h starts a verify
    a_odd_opcode_go: assert property (@(posedge clk_in) disable iff (srst_in) // [R1]
        (state_q == RVS_ST_IDLE && wr_in && addr_in == RVS_OFS_CMD_STAT
         && wdata_in == 8'h41) |=> (state_q == RVS_ST_ISSUE && busy_out))
        else $error("opcode 41h did not start a verify");

    // [R2] retry bit changes nothing
    a_retry_ignored: assert property (@(posedge clk_in) disable iff (srst_in) // [R2]
        go28 |=> (state_q == RVS_ST_ISSUE) ##1 media_req_valid_out)
        else $error("verify opcode did not issue a sector check");

    // [R3] status never shows a transfer request
    a_no_transfer: assert property (@(posedge clk_in) disable iff (srst_in) // [R3]
        ($past(rd_in) && $past(addr_in) == RVS_OFS_CMD_STAT) |-> !rdata_out[3])
        else $error("transfer request seen in status");

    // [R4] no further request after a failing sector
    a_stop_on_fail: assert property (@(posedge clk_in) disable iff (srst_in) // [R4]
        (state_q == RVS_ST_WAIT && media_rsp_in.done && sector_fail)
        |=> (state_q == RVS_ST_DONE) ##1 (state_q == RVS_ST_IDLE && !busy_out))
        else $error("verify went on after a failing sector");

    // [R5] zero count gives 256 sectors
    a_count_256: assert property (@(posedge clk_in) disable iff (srst_in) // [R5]
        (go28 && cnt_q == 8'h0) |=> remain_q == 17'h00100)
        else $error("zero count not taken as 256");

    // [R7] logical address packed from the registers
    a_lba_pack: assert property (@(posedge clk_in) disable iff (srst_in) // [R7]
        go28 |=> cur_addr_q[27:0] == {devhead_q[3:0], ch_q, cl_q, sn_q})
        else $error("start address packed wrongly");

    // [R8] clean finish leaves nothing unverified
    a_clean_zero: assert property (@(posedge clk_in) disable iff (srst_in) // [R8]
        (state_q == RVS_ST_DONE && busy_out && !errbit_q) |=> cnt_q == 8'h0)
        else $error("count not zero after clean finish");

    // [R10] reserved error bits stay zero
    a_err_legal: assert property (@(posedge clk_in) disable iff (srst_in) // [R10]
        (err_q & ~RVS_ERR_LEGAL_MASK) == 8'h0)
        else $error("illegal error bit set");

    // [R11] ending status has busy clear and ready set
    a_end_status: assert property (@(posedge clk_in) disable iff (srst_in) // [R11]
        $fell(busy_out) |-> (status[6] && status[4] && !status[5] && !status[2]
                             && status[0] == (err_q != 8'h0)))
        else $error("wrong ending status");

    // [R13] extended zero count gives 65536
    a_count_65536: assert property (@(posedge clk_in) disable iff (srst_in) // [R13]
        (go48 && cnt_q == 8'h0 && cnt_prev_q == 8'h0) |=> remain_q == 17'h10000)
        else $error("extended zero count not 65536");

endmodule : rvs_verify_cmd

// ===== rvs_media_model.sv
// behavioural media engine answering sector check requests
`timescale 1ns/1ps
module rvs_media_model
    import rvs_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic srst_in, // sync reset
    input wire logic clr_in, // clear counters
    input wire logic req_valid_in, // sector request
    input wire rvs_media_req_t req_in, // sector address
    input wire logic [1:0] kind_in, // 1 unc, 2 not found
    input wire logic [7:0] fail_in, // failing address low byte
    output rvs_media_rsp_t rsp_out, // sector result
    output logic [16:0] nreq_out, // requests since clear
    output logic [47:0] first_out // first request since clear
);
    logic pend_q;
    logic tog_q;
    logic [1:0] wait_q;
    logic [47:0] addr_q;
    logic hit;

    // failing sector chosen by the bench
    assign hit = addr_q[7:0] == fail_in;

    // odd addresses answer 3 cycles late; flags toggle outside done
    always_ff @(posedge clk_in) begin
        tog_q <= ~tog_q;
        rsp_out <= {1'b0, tog_q, ~tog_q};
        if (srst_in || clr_in) begin
            pend_q <= 1'b0;
            tog_q <= 1'b0;
            nreq_out <= 17'h0;
        end else if (req_valid_in) begin
            pend_q <= 1'b1;
            wait_q <= {2{req_in.addr[0]}};
            addr_q <= req_in.addr;
            nreq_out <= nreq_out + 17'h1;
            if (nreq_out == 17'h0)
                first_out <= req_in.addr;
        end else if (pend_q && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            rsp_out <= {1'b1, hit && kind_in == 2'h1, hit && kind_in == 2'h2};
        end
    end
endmodule : rvs_media_model

// ===== rvs_verify_cmd_tb.sv
// self-checking bench for the sector verify command handler
`timescale 1ns/1ps
module rvs_verify_cmd_tb
    import rvs_pkg::*;
;
    typedef struct packed {
        logic [7:0] op, dh, sn, cl, ch, cnt;
        logic [1:0] fk;
        logic [7:0] fl, ec, es, ee, est;
        logic [16:0] nq;
    } rvs_row_t;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic clr = 1'b0;
    logic [1:0] fkind = 2'h0;
    logic [7:0] flo = 8'h00;
    logic [7:0] rdata, got;
    logic irq, busy, mv;
    rvs_media_req_t mreq;
    rvs_media_rsp_t mrsp;
    logic [16:0] nreq;
    logic [47:0] first;
    int fail_count = 0;
    int num_checks = 0;
    int i;
    rvs_row_t r;
    rvs_row_t rows [7] = '{
        '{8'h40, 8'he1, 8'h10, 8'h22, 8'h33, 8'h03, 2'h0, 8'h00, 8'h00, 8'h12, 8'h00, 8'h50, 17'h3},
        '{8'h41, 8'he1, 8'hfe, 8'h22, 8'h33, 8'h03, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 17'h3},
        '{8'h42, 8'h40, 8'h10, 8'h22, 8'h33, 8'h02, 2'h0, 8'h00, 8'h00, 8'h11, 8'h00, 8'h50, 17'h2},
        '{8'h40, 8'ha0, 8'h01, 8'h00, 8'h00, 8'h02, 2'h0, 8'h00, 8'h00, 8'h02, 8'h00, 8'h50, 17'h2},
        '{8'h50, 8'he0, 8'h10, 8'h00, 8'h00, 8'h03, 2'h0, 8'h00, 8'h03, 8'h10, 8'h04, 8'h51, 17'h0},
        '{8'h41, 8'he0, 8'h20, 8'h00, 8'h00, 8'h04, 2'h1, 8'h22, 8'h02, 8'h22, 8'h40, 8'h51, 17'h3},
        '{8'h42, 8'h40, 8'h30, 8'h00, 8'h00, 8'h05, 2'h2, 8'h30, 8'h05, 8'h30, 8'h10, 8'h51, 17'h1}
    };

    // free-running clock, 8 ns period
    always #4 clk_in = ~clk_in;

    rvs_verify_cmd u_rvs_verify_cmd (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .irq_out(irq),
        .busy_out(busy), .media_req_valid_out(mv), .media_req_out(mreq), .media_rsp_in(mrsp));
    rvs_media_model u_rvs_media_model (.clk_in(clk_in), .srst_in(srst_in), .clr_in(clr),
        .req_valid_in(mv), .req_in(mreq), .kind_in(fkind), .fail_in(flo), .rsp_out(mrsp),
        .nreq_out(nreq), .first_out(first));

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // one write cycle, then a gap cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    // read data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        @(negedge clk_in);
        d = rdata;
        @(posedge clk_in);
    endtask : rd

    // no task file access until busy drops
    task automatic idle();
        for (i = 0; i < 4000 && (i < 3 || busy); i++) @(posedge clk_in);
        if (i == 4000) begin
            fail_count++;
            close_out();
        end
    endtask : idle

    // parameters first, previous bytes before current
    task automatic load(input rvs_row_t q);
        wr(RVS_OFS_COUNT, 8'h00);
        wr(RVS_OFS_COUNT, q.cnt);
        wr(RVS_OFS_SECNUM, 8'h44);
        wr(RVS_OFS_SECNUM, q.sn);
        wr(RVS_OFS_CYL_LO, 8'h55);
        wr(RVS_OFS_CYL_LO, q.cl);
        wr(RVS_OFS_CYL_HI, 8'h66);
        wr(RVS_OFS_CYL_HI, q.ch);
        wr(RVS_OFS_DEVHEAD, q.dh);
    endtask : load

    function automatic logic [47:0] first_of(input rvs_row_t q);
        if (q.op == RVS_OP_VERIFY48)
            return {24'h665544, q.ch, q.cl, q.sn};
        return {20'h0, q.dh[3:0], q.ch, q.cl, q.sn};
    endfunction : first_of

    // reset values, table of commands, then awkward cases
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(RVS_OFS_DEVHEAD, got);
        chk(got, RVS_DEVHEAD_RST);
        rd(RVS_OFS_CMD_STAT, got);
        chk(got, 8'h50);
        foreach (rows[k]) begin
            r = rows[k];
            fkind <= r.fk;
            flo <= r.fl;
            load(r);
            clr <= 1'b1;
            wr(RVS_OFS_CMD_STAT, r.op);
            clr <= 1'b0;
            idle();
            rd(RVS_OFS_COUNT, got);
            chk(got, r.ec);
            rd(RVS_OFS_SECNUM, got);
            chk(got, r.es);
            rd(RVS_OFS_ERROR, got);
            chk(got, r.ee);
            rd(RVS_OFS_CMD_STAT, got);
            chk(got, r.est);
            chk(nreq, r.nq);
            if (r.nq != 17'h0) begin
                chk(first, first_of(r));
                chk(mreq.lba_mode, r.op == RVS_OP_VERIFY48 || r.dh[6]);
                chk(mreq.addr[7:0], r.es);
            end
        end
        // upper address bytes of the failing extended sector
        wr(RVS_OFS_DEVCTL, 8'h80);
        rd(RVS_OFS_SECNUM, got);
        chk(got, 8'h44);
        rd(RVS_OFS_CYL_HI, got);
        chk(got, 8'h66);
        wr(RVS_OFS_DEVCTL, 8'h00);
        rd(4'hf, got);
        chk(got, 8'h00);
        // sticky flags masked, then raised and cleared
        rd(RVS_OFS_IRQ_STAT, got);
        chk(got, 8'h03);
        chk(irq, 1'b0);
        wr(RVS_OFS_IRQ_MASK, 8'h03);
        @(negedge clk_in);
        chk(irq, 1'b1);
        @(posedge clk_in);
        wr(RVS_OFS_IRQ_STAT, 8'h03);
        @(negedge clk_in);
        chk(irq, 1'b0);
        @(posedge clk_in);
        // zero count runs 256 sectors; a write while busy is dropped
        fkind <= 2'h0;
        r.cnt = 8'h00;
        r.sn = 8'h00;
        r.dh = 8'he0;
        load(r);
        clr <= 1'b1;
        wr(RVS_OFS_CMD_STAT, 8'h40);
        clr <= 1'b0;
        wr(RVS_OFS_SECNUM, 8'h77);
        rd(RVS_OFS_CMD_STAT, got);
        chk(got, 8'hd0);
        chk(busy, 1'b1);
        idle();
        chk(nreq, 17'h00100);
        rd(RVS_OFS_SECNUM, got);
        chk(got, 8'hff);
        close_out();
    end
endmodule : rvs_verify_cmd_tb
